// ### src/vsc_pkg.sv
// Constants, command codes and state types of the video DRAM host controller.
package vsc_pkg;
  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam int vsc_reg_aw = 5;
  localparam logic [4:0] vsc_reg_cmd = 5'h00;
  localparam logic [4:0] vsc_reg_addr = 5'h04;
  localparam logic [4:0] vsc_reg_wdata = 5'h08;
  localparam logic [4:0] vsc_reg_status = 5'h0c;
  localparam logic [4:0] vsc_reg_serial = 5'h10;
  localparam logic [4:0] vsc_reg_data = 5'h14;
  localparam logic [4:0] vsc_reg_ctrl = 5'h18;
  localparam int vsc_lanes_lsb = 4;
  localparam int vsc_col_lsb = 16;
  localparam int vsc_mask_bit = 16;
  localparam int vsc_auto_bit = 0;
  localparam int vsc_clr_bit = 1;
  // ----------------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    vsc_op_read = 4'h0,
    vsc_op_write = 4'h1,
    vsc_op_rd_xfer = 4'h2,
    vsc_op_wr_xfer = 4'h3,
    vsc_op_split_rd = 4'h4,
    vsc_op_stop_column_set_cycle = 4'h5,
    vsc_op_mode_reset_refresh_cycle = 4'h6,
    vsc_op_plain_refresh_cycle = 4'h7,
    vsc_op_row_ref = 4'h8,
    vsc_op_hidden = 4'h9
  } vsc_op_t;
  typedef enum logic [6:0] {
    s_idle = 7'h01, s_setup = 7'h02, s_ras = 7'h04, s_cas = 7'h08,
    s_hpre = 7'h10, s_hras = 7'h20, s_prech = 7'h40
  } vsc_seq_t;
  typedef enum logic [2:0] {q_idle = 3'h1, q_low = 3'h2, q_high = 3'h4} vsc_ser_t;
  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam int vsc_clk_ns = 10;
  localparam int vsc_t_ras_ns = 70;
  localparam int vsc_t_rp_ns = 50;
  localparam int vsc_t_cas_ns = 20;
  localparam int vsc_t_setup_ns = 10;
  localparam int vsc_sc_half_ns = 60;
  localparam logic [3:0] vsc_ras_cyc = 4'((vsc_t_ras_ns + vsc_clk_ns - 1) / vsc_clk_ns);
  localparam logic [3:0] vsc_rp_cyc = 4'((vsc_t_rp_ns + vsc_clk_ns - 1) / vsc_clk_ns);
  localparam logic [3:0] vsc_cas_cyc = 4'((vsc_t_cas_ns + vsc_clk_ns - 1) / vsc_clk_ns);
  localparam logic [3:0] vsc_setup_cyc = 4'((vsc_t_setup_ns + vsc_clk_ns - 1) / vsc_clk_ns);
  localparam logic [3:0] vsc_sc_half_cyc = 4'((vsc_sc_half_ns + vsc_clk_ns - 1) / vsc_clk_ns);
  localparam logic [3:0] vsc_sync_depth = 4'h3;
  localparam int vsc_refresh_ms = 8;
  localparam int vsc_refresh_rows = 512;
  localparam int vsc_refresh_period_cyc = vsc_refresh_ms * 1000000 / vsc_clk_ns;
  localparam logic [2:0] vsc_bnd_reset = 3'h5;
endpackage

// ### src/vsc_host.sv
// Host controller that drives a multiport video DRAM through its pins.
module vsc_host #(
  parameter int refresh_period_cycles = vsc_pkg::vsc_refresh_period_cyc
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [vsc_pkg::vsc_reg_aw-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic lower_byte_write_strobe_n,
  output logic upper_byte_write_strobe_n,
  output logic special_function_select,
  output logic transfer_output_enable_n,
  output logic [8:0] mem_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic serial_shift_clock,
  output logic serial_port_enable_n,
  input wire logic [15:0] sdq_in,
  output logic [15:0] sdq_out,
  output logic sdq_oe
);
  import vsc_pkg::*;
  localparam logic [19:0] ref_last = 20'(refresh_period_cycles / vsc_refresh_rows - 1);

  function automatic logic is_cbr(vsc_op_t o);
    return o inside {vsc_op_stop_column_set_cycle, vsc_op_mode_reset_refresh_cycle,
                     vsc_op_plain_refresh_cycle};
  endfunction

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n_s;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n_s = rst_pipe[1];

  logic [15:0] dq_s1, dq_s2, dq_s3, dq_st, next_dq_st;
  logic [15:0] sd_s1, sd_s2, sd_s3, sd_st, next_sd_st;
  always_comb
  begin
    next_dq_st = (dq_s3 & ~(dq_s2 ^ dq_s3)) | (dq_st & (dq_s2 ^ dq_s3));
    next_sd_st = (sd_s3 & ~(sd_s2 ^ sd_s3)) | (sd_st & (sd_s2 ^ sd_s3));
  end
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      {dq_s1, dq_s2, dq_s3, dq_st} <= 64'h0;
      {sd_s1, sd_s2, sd_s3, sd_st} <= 64'h0;
    end
    else if (ce)
    begin
      {dq_s1, dq_s2, dq_s3, dq_st} <= {dq_in, dq_s1, dq_s2, next_dq_st};
      {sd_s1, sd_s2, sd_s3, sd_st} <= {sdq_in, sd_s1, sd_s2, next_sd_st};
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  vsc_op_t op_q, next_op_q, cur_op, next_cur_op;
  vsc_seq_t st, next_st;
  vsc_ser_t sst, next_sst;
  logic cmd_pend, next_cmd_pend, ser_pend, next_ser_pend, auto_ref, next_auto_ref;
  logic [1:0] lanes_q, next_lanes_q;
  logic [8:0] row_q, next_row_q;
  logic [7:0] col_q, next_col_q;
  logic [15:0] wdata_q, next_wdata_q, ser_data_q, next_ser_data_q;
  logic ser_mask_q, next_ser_mask_q, clr_miss, seq_go, ser_go, ras_fall, ref_due;
  logic [31:0] next_rdata, status;
  logic [15:0] ram_rd, ser_rd;
  logic [7:0] ptr;
  logic wmode, stop_act, miss, split_pend;
  logic [2:0] bnd_set, bnd_live;

  assign status = {8'h0, ptr, 2'h0, bnd_set, bnd_live, ref_due, miss, stop_act, wmode,
                   ser_pend, cmd_pend, sst != q_idle, st != s_idle};
  assign clr_miss = reg_wr && reg_addr == vsc_reg_ctrl && reg_wdata[vsc_clr_bit];
  always_comb
  begin
    next_op_q = op_q;
    {next_lanes_q, next_row_q, next_col_q} = {lanes_q, row_q, col_q};
    {next_wdata_q, next_ser_data_q, next_ser_mask_q} = {wdata_q, ser_data_q, ser_mask_q};
    next_cmd_pend = cmd_pend && !(seq_go && cmd_pend);
    next_ser_pend = ser_pend && !ser_go;
    next_auto_ref = auto_ref;
    next_rdata = 32'h0;
    if (reg_wr)
      case (reg_addr)
        vsc_reg_cmd: if (!cmd_pend && st == s_idle && reg_wdata[3:0] <= vsc_op_hidden)
        begin
          next_op_q = vsc_op_t'(reg_wdata[3:0]);
          next_lanes_q = reg_wdata[vsc_lanes_lsb +: 2];
          next_cmd_pend = 1'b1;
        end
        vsc_reg_addr:
        begin
          next_row_q = reg_wdata[8:0];
          next_col_q = reg_wdata[vsc_col_lsb +: 8];
        end
        vsc_reg_wdata: next_wdata_q = reg_wdata[15:0];
        vsc_reg_serial: if (!ser_pend && sst == q_idle)
        begin
          next_ser_data_q = reg_wdata[15:0];
          next_ser_mask_q = reg_wdata[vsc_mask_bit];
          next_ser_pend = 1'b1;
        end
        vsc_reg_ctrl: next_auto_ref = reg_wdata[vsc_auto_bit];
        default: ;
      endcase
    if (reg_rd)
      case (reg_addr)
        vsc_reg_cmd: next_rdata = {26'h0, lanes_q, op_q};
        vsc_reg_addr: next_rdata = {8'h0, col_q, 7'h0, row_q};
        vsc_reg_wdata: next_rdata = {16'h0, wdata_q};
        vsc_reg_status: next_rdata = status;
        vsc_reg_serial: next_rdata = {15'h0, ser_mask_q, ser_data_q};
        vsc_reg_data: next_rdata = {ram_rd, ser_rd};
        vsc_reg_ctrl: next_rdata = {31'h0, auto_ref};
        default: next_rdata = 32'h0;
      endcase
  end
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      op_q <= vsc_op_read;
      {lanes_q, row_q, col_q, wdata_q} <= '0;
      {ser_data_q, ser_mask_q, cmd_pend, ser_pend, auto_ref, reg_rdata} <= '0;
    end
    else if (ce)
    begin
      op_q <= next_op_q;
      {lanes_q, row_q, col_q} <= {next_lanes_q, next_row_q, next_col_q};
      {wdata_q, ser_data_q, ser_mask_q} <= {next_wdata_q, next_ser_data_q, next_ser_mask_q};
      {cmd_pend, ser_pend, auto_ref} <= {next_cmd_pend, next_ser_pend, next_auto_ref};
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------------
  logic [19:0] rcnt, next_rcnt;
  logic next_ref_due, tick;
  always_comb
  begin
    tick = rcnt == ref_last;
    next_rcnt = tick ? 20'h0 : rcnt + 20'h1;
    // A tick in the very cycle the due flag is taken still sets it again.
    next_ref_due = (ref_due && !(seq_go && !cmd_pend)) || (tick && auto_ref);
  end
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s) {rcnt, ref_due} <= '0;
    else if (ce) {rcnt, ref_due} <= {next_rcnt, next_ref_due};
  end

  // ----------------------------------------------------------------------
  // Cycle sequencer and memory pins
  // ----------------------------------------------------------------------
  logic [3:0] cnt, next_cnt;
  logic [15:0] next_ram_rd;
  logic n_ras, n_cas, n_lo, n_up, n_sfs, n_oe, n_dqoe, cbr_n, rd_n, ph_row;
  logic [8:0] n_addr;
  always_comb
  begin
    next_st = st;
    next_cur_op = cur_op;
    next_ram_rd = ram_rd;
    next_cnt = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
    seq_go = 1'b0;
    unique case (st)
      s_idle: if ((cmd_pend || ref_due) && sst == q_idle)
      begin
        seq_go = 1'b1;
        next_cur_op = cmd_pend ? op_q : vsc_op_plain_refresh_cycle;
        next_st = s_setup;
        next_cnt = vsc_setup_cyc;
      end
      s_setup: if (cnt == 4'h0)
      begin
        next_st = s_ras;
        next_cnt = vsc_ras_cyc;
      end
      s_ras: if (cnt == 4'h0)
      begin
        next_st = (is_cbr(cur_op) || cur_op == vsc_op_row_ref) ? s_prech : s_cas;
        next_cnt = (next_st == s_prech) ? vsc_rp_cyc : vsc_cas_cyc + vsc_sync_depth;
      end
      s_cas: if (cnt == 4'h0)
      begin
        next_ram_rd = dq_st;
        next_st = (cur_op == vsc_op_hidden) ? s_hpre : s_prech;
        next_cnt = vsc_rp_cyc;
      end
      s_hpre: if (cnt == 4'h0)
      begin
        next_st = s_hras;
        next_cnt = vsc_ras_cyc;
      end
      s_hras: if (cnt == 4'h0)
      begin
        next_st = s_prech;
        next_cnt = vsc_rp_cyc;
      end
      s_prech: if (cnt == 4'h0) next_st = s_idle;
    endcase
    ras_fall = next_st inside {s_ras, s_hras} && st != next_st;
    // Every cycle but a RAM-side write, whose lanes fall with the column strobe, is decided by the levels at the row strobe fall.
    cbr_n = is_cbr(next_cur_op);
    rd_n = next_cur_op inside {vsc_op_read, vsc_op_hidden};
    ph_row = next_st inside {s_setup, s_ras};
    n_ras = !(next_st inside {s_ras, s_cas, s_hras});
    n_cas = !(next_st inside {s_cas, s_hpre, s_hras} || (cbr_n && ph_row));
    // Hidden refresh holds column strobe and output enable low across the second row fall.
    n_oe = !((next_cur_op inside {vsc_op_rd_xfer, vsc_op_wr_xfer, vsc_op_split_rd}
              && next_st inside {s_setup, s_ras, s_cas})
             || (rd_n && next_st inside {s_cas, s_hpre, s_hras}));
    n_lo = 1'b1;
    n_up = 1'b1;
    // Byte lanes only on RAM-side writes; write transfers and stop-column sets drive the strobes by the code.
    if (next_cur_op == vsc_op_write && next_st == s_cas)
    begin
      n_lo = !lanes_q[0];
      n_up = !lanes_q[1];
    end
    else if (next_cur_op == vsc_op_wr_xfer && next_st inside {s_setup, s_ras, s_cas})
      {n_up, n_lo} = 2'h0;
    else if (next_cur_op == vsc_op_stop_column_set_cycle && ph_row)
      n_lo = 1'b0;
    n_sfs = ph_row && next_cur_op inside {vsc_op_split_rd, vsc_op_stop_column_set_cycle,
                                          vsc_op_plain_refresh_cycle};
    // Row field carries A2..A6 of the boundary code on a stop-column set.
    n_addr = ph_row ? row_q : (next_st == s_cas ? {1'b0, col_q} : 9'h0);
    n_dqoe = !cbr_n && ((next_cur_op == vsc_op_write && next_st == s_cas)
             || (next_cur_op == vsc_op_wr_xfer && ph_row));
  end
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      st <= s_idle;
      cur_op <= vsc_op_read;
      {cnt, ram_rd} <= {4'h0, 16'h0};
      {row_strobe_n, column_strobe_n, lower_byte_write_strobe_n} <= 3'h7;
      {upper_byte_write_strobe_n, transfer_output_enable_n} <= 2'h3;
      {special_function_select, mem_addr, dq_out, dq_oe} <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
      cur_op <= next_cur_op;
      {cnt, ram_rd} <= {next_cnt, next_ram_rd};
      {row_strobe_n, column_strobe_n, lower_byte_write_strobe_n} <= {n_ras, n_cas, n_lo};
      {upper_byte_write_strobe_n, transfer_output_enable_n} <= {n_up, n_oe};
      {special_function_select, mem_addr, dq_out, dq_oe} <= {n_sfs, n_addr, wdata_q, n_dqoe};
    end
  end

  // ----------------------------------------------------------------------
  // Serial port and pointer mirror
  // ----------------------------------------------------------------------
  logic [3:0] scnt, next_scnt;
  logic n_sc, n_se, n_soe, at_bnd, next_wmode, next_stop, next_miss, next_spend;
  logic [15:0] n_sout, next_ser_rd;
  logic [7:0] next_ptr, bmask, split_start, next_sstart;
  logic [2:0] next_bset, next_blive;
  always_comb
  begin
    next_sst = sst;
    {n_sc, n_se, n_soe, n_sout} = {serial_shift_clock, serial_port_enable_n, sdq_oe, sdq_out};
    {next_ptr, next_wmode, next_stop, next_bset, next_blive} = {ptr, wmode, stop_act, bnd_set,
                                                                 bnd_live};
    {next_sstart, next_spend, next_ser_rd} = {split_start, split_pend, ser_rd};
    next_miss = miss && !clr_miss;
    next_scnt = (scnt == 4'h0) ? 4'h0 : scnt - 4'h1;
    ser_go = 1'b0;
    bmask = 8'((9'h4 << bnd_live) - 9'h1);
    at_bnd = stop_act ? (ptr & bmask) == bmask : ptr[6:0] == 7'h7f;
    unique case (sst)
      q_idle: if (ser_pend && st == s_idle && !seq_go)
      begin
        ser_go = 1'b1;
        next_sst = q_low;
        next_scnt = vsc_sc_half_cyc;
        n_se = ser_mask_q;
        n_soe = wmode && !ser_mask_q;
        n_sout = ser_data_q;
      end
      q_low: if (scnt == 4'h0)
      begin
        next_sst = q_high;
        next_scnt = vsc_sc_half_cyc;
        n_sc = 1'b1;
        if (at_bnd && split_pend)
        begin
          next_ptr = split_start;
          next_spend = 1'b0;
        end
        else
        begin
          // Without a split transfer the device cannot cross a stop-column boundary, so flag it in stop mode.
          next_miss = next_miss || (at_bnd && stop_act);
          next_ptr = ptr + 8'h1;
        end
      end
      q_high: if (scnt == 4'h0)
      begin
        if (!wmode && !serial_port_enable_n) next_ser_rd = sd_st;
        next_sst = q_idle;
        {n_sc, n_se, n_soe} = 3'h2;
      end
    endcase
    if (ras_fall && st == s_setup)
      unique case (cur_op)
        vsc_op_rd_xfer, vsc_op_wr_xfer:
        begin
          next_ptr = col_q;
          next_wmode = cur_op == vsc_op_wr_xfer;
          next_spend = 1'b0;
        end
        vsc_op_split_rd:
        begin
          next_sstart = {!ptr[7], col_q[6:0]};
          next_spend = 1'b1;
          next_blive = bnd_set;
        end
        vsc_op_stop_column_set_cycle:
        begin
          next_stop = 1'b1;
          next_bset = 3'h0;
          for (int i = 0; i < 5; i++)
            if (row_q[2 + i] && next_bset == 3'(i)) next_bset = next_bset + 3'h1;
        end
        vsc_op_mode_reset_refresh_cycle:
        begin
          next_stop = 1'b0;
          {next_bset, next_blive} = {vsc_bnd_reset, vsc_bnd_reset};
        end
        default: ;
      endcase
  end
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      sst <= q_idle;
      {scnt, serial_shift_clock, serial_port_enable_n} <= {4'h0, 1'b0, 1'b1};
      {sdq_oe, sdq_out, ptr, wmode, stop_act, miss, split_pend, split_start, ser_rd} <= '0;
      {bnd_set, bnd_live} <= {vsc_bnd_reset, vsc_bnd_reset};
    end
    else if (ce)
    begin
      sst <= next_sst;
      {scnt, serial_shift_clock, serial_port_enable_n} <= {next_scnt, n_sc, n_se};
      {sdq_oe, sdq_out, ptr, wmode, stop_act} <= {n_soe, n_sout, next_ptr, next_wmode, next_stop};
      {miss, split_pend, split_start, ser_rd} <= {next_miss, next_spend, next_sstart, next_ser_rd};
      {bnd_set, bnd_live} <= {next_bset, next_blive};
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n_s);
  stop_set_pins_a: assert property ($fell(row_strobe_n) && cur_op == vsc_op_stop_column_set_cycle
    |-> !column_strobe_n && !lower_byte_write_strobe_n && special_function_select)
    else $error("stop column set pins wrong");
  reset_pins_a: assert property ($fell(row_strobe_n) && cur_op == vsc_op_mode_reset_refresh_cycle
    |-> !column_strobe_n && lower_byte_write_strobe_n && upper_byte_write_strobe_n
        && !special_function_select)
    else $error("mode reset pins wrong");
  plain_ref_a: assert property ($fell(row_strobe_n) && cur_op == vsc_op_plain_refresh_cycle
    |-> !column_strobe_n && upper_byte_write_strobe_n && special_function_select && !dq_oe)
    else $error("plain refresh pins wrong");
  row_only_a: assert property ($fell(row_strobe_n) && cur_op == vsc_op_row_ref
    |-> (column_strobe_n && transfer_output_enable_n) [*7])
    else $error("row refresh strobes wrong");
  split_lane_a: assert property (!row_strobe_n && cur_op == vsc_op_split_rd
    |-> upper_byte_write_strobe_n && lower_byte_write_strobe_n)
    else $error("byte lane in split transfer");
  hidden_ref_a: assert property ($fell(row_strobe_n) && !column_strobe_n
    && cur_op == vsc_op_hidden |-> !transfer_output_enable_n)
    else $error("hidden refresh lost output enable");
  ser_mask_a: assert property ($rose(serial_shift_clock) && serial_port_enable_n
    |-> !sdq_oe)
    else $error("masked serial word driven");
  ptr_wrap_a: assert property (ce && sst == q_low && scnt == 4'h0 && ptr == 8'hff
    && !split_pend |=> ptr == 8'h00)
    else $error("serial pointer did not wrap");
  reset_bnd_a: assert property (ce && ras_fall && st == s_setup
    && cur_op == vsc_op_mode_reset_refresh_cycle |=> !stop_act && bnd_live == vsc_bnd_reset)
    else $error("boundary not reset");
  bnd_defer_a: assert property (ce && ras_fall && cur_op == vsc_op_stop_column_set_cycle
    |=> bnd_live == $past(bnd_live))
    else $error("boundary applied early");
  rd_xfer_c: cover property ($fell(row_strobe_n) && cur_op == vsc_op_rd_xfer);
  ser_wr_c: cover property ($rose(serial_shift_clock) && wmode && sdq_oe);
  jump_c: cover property (sst == q_low && scnt == 4'h0 && at_bnd && split_pend && stop_act);
endmodule // vsc_host

// ### verification/vsc_dram_model.sv
// Behavioural video DRAM that answers the host controller's pins.
module vsc_dram_model (
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic lower_byte_write_strobe_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic special_function_select,
  input wire logic transfer_output_enable_n,
  input wire logic [8:0] mem_addr,
  input wire logic serial_shift_clock,
  input wire logic serial_port_enable_n,
  input wire logic [15:0] sdq_out,
  output logic [15:0] sdq_in,
  output logic [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stop_mode = 1'b0;
  logic write_mode = 1'b0;
  logic xfer_pend = 1'b0;
  logic [2:0] code = 3'h5;
  logic [1:0] lanes = 2'h0;
  logic [7:0] ptr = 8'h00;
  logic [15:0] captured = 16'h0000;
  logic no_we;
  assign no_we = lower_byte_write_strobe_n && upper_byte_write_strobe_n;
  assign dq_in = 16'h5a5a;
  initial sdq_in = 16'h0000;
  always @(negedge row_strobe_n)
  begin
    xfer_pend = 1'b0;
    if (!column_strobe_n && special_function_select && !no_we)
    begin
      stop_mode = 1'b1;
      code = 3'h0;
      while (code < 3'h5 && mem_addr[32'(code) + 2]) code = code + 3'h1;
    end
    else if (!column_strobe_n && !special_function_select && no_we)
    begin
      stop_mode = 1'b0;
      code = 3'h5;
    end
    // Other column-first cycles only refresh, so no state moves.
    else if (column_strobe_n && !transfer_output_enable_n && !special_function_select)
    begin
      xfer_pend = 1'b1;
      write_mode = !no_we;
    end
  end
  // Lanes may fall after the column strobe in early write, so both edges are watched.
  always @(negedge column_strobe_n or negedge lower_byte_write_strobe_n
           or negedge upper_byte_write_strobe_n)
  begin
    if (!row_strobe_n && !column_strobe_n && xfer_pend)
      ptr = mem_addr[7:0];
    else if (!row_strobe_n && !column_strobe_n)
      lanes = {!upper_byte_write_strobe_n, !lower_byte_write_strobe_n};
  end
  always @(posedge serial_shift_clock)
  begin
    if (!write_mode && !serial_port_enable_n)
      sdq_in = {8'ha5, ptr};
    else
      sdq_in = ~sdq_in;
    if (write_mode && !serial_port_enable_n)
      captured = sdq_out;
    ptr = ptr + 8'h01;
  end
endmodule // vsc_dram_model

// ### verification/vsc_host_bench.sv
// Self-checking bench for the video DRAM host controller.
module vsc_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import vsc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, rd_val;
  logic ras_n, cas_n, wel_n, weu_n, sfs, dt_n, sc, se_n, dq_oe, sdq_oe;
  logic [8:0] mem_addr;
  logic [15:0] dq_in, dq_out, sdq_in, sdq_out;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  vsc_host #(.refresh_period_cycles(5120)) vsc_host_i (.clk(clk), .rstn(rstn), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .lower_byte_write_strobe_n(wel_n), .upper_byte_write_strobe_n(weu_n),
    .special_function_select(sfs), .transfer_output_enable_n(dt_n), .mem_addr(mem_addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .serial_shift_clock(sc),
    .serial_port_enable_n(se_n), .sdq_in(sdq_in), .sdq_out(sdq_out), .sdq_oe(sdq_oe));
  vsc_dram_model vsc_dram_model_i (.row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .lower_byte_write_strobe_n(wel_n), .upper_byte_write_strobe_n(weu_n),
    .special_function_select(sfs), .transfer_output_enable_n(dt_n), .mem_addr(mem_addr),
    .serial_shift_clock(sc), .serial_port_enable_n(se_n), .sdq_out(sdq_out),
    .sdq_in(sdq_in), .dq_in(dq_in));
  // ----------------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Polling is bounded; a stuck busy flag shows up as failed checks afterwards.
  task automatic idle();
    int n;
    n = 0;
    rd(vsc_reg_status);
    while (rd_val[3:0] !== 4'h0 && n < 400)
    begin
      rd(vsc_reg_status);
      n++;
    end
  endtask
  task automatic go(input logic [31:0] cmd, input logic [31:0] a);
    wr(vsc_reg_addr, a);
    wr(vsc_reg_cmd, cmd);
    idle();
  endtask
  task automatic ser(input logic [31:0] d);
    wr(vsc_reg_serial, d);
    idle();
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(5'h1c);
    chk("unmapped", 32'h0, rd_val);
    for (int k = 5; k >= 0; k--)
    begin
      go(32'(vsc_op_stop_column_set_cycle) | 32'h10, (32'((1 << k) - 1) << 2) | 32'h83);
      rd(vsc_reg_status);
      chk("set code", 32'(k), 32'(rd_val[13:11]));
      chk("stop bit", 32'h1, 32'(rd_val[5]));
      chk("live code", 32'h5, 32'(rd_val[10:8]));
      chk("model code", 32'(k), 32'(vsc_dram_model_i.code));
    end
    go(32'(vsc_op_plain_refresh_cycle), 32'h0);
    chk("refresh keeps", 32'h8, {vsc_dram_model_i.stop_mode, vsc_dram_model_i.code});
    go(32'(vsc_op_mode_reset_refresh_cycle), 32'h0);
    chk("reset clears", 32'h5, {vsc_dram_model_i.stop_mode, vsc_dram_model_i.code});
    for (int l = 1; l < 3; l++)
    begin
      go(32'(vsc_op_write) | 32'(l << 4), 32'h0030_0010);
      chk("lanes", 32'(l), 32'(vsc_dram_model_i.lanes));
    end
    go(32'(vsc_op_rd_xfer), 32'h00fe_0020);
    for (int i = 0; i < 3; i++)
    begin
      ser(32'h0);
      rd(vsc_reg_data);
      chk("serial read", 32'({8'ha5, 8'(8'hfe + 8'(i))}),
        32'(rd_val[15:0]));
    end
    ser(32'h1_0000);
    chk("masked read ptr", 32'h02, 32'(vsc_dram_model_i.ptr));
    go(32'(vsc_op_wr_xfer), 32'h0010_0040);
    ser(32'h1234);
    chk("serial write", 32'h1234, 32'(vsc_dram_model_i.captured));
    ser(32'h1_beef);
    chk("masked write", 32'h1234, 32'(vsc_dram_model_i.captured));
    chk("write ptr", 32'h12, 32'(vsc_dram_model_i.ptr));
    go(32'(vsc_op_row_ref), 32'h0000_0033);
    chk("row ref keeps", 32'h12, 32'(vsc_dram_model_i.ptr));
    go(32'(vsc_op_hidden), 32'h0005_0021);
    rd(vsc_reg_data);
    chk("hidden read", 32'h5a5a, 32'(rd_val[31:16]));
    // Four-column boundaries; the split start lands in the other half.
    go(32'(vsc_op_stop_column_set_cycle) | 32'h10, 32'h0);
    go(32'(vsc_op_rd_xfer), 32'h0);
    go(32'(vsc_op_split_rd), 32'h0010_0000);
    rd(vsc_reg_status);
    chk("split live code", 32'h0, 32'(rd_val[10:8]));
    repeat (4) ser(32'h0);
    rd(vsc_reg_status);
    chk("jump ptr", 32'h90, 32'(rd_val[23:16]));
    chk("no miss", 32'h0, 32'(rd_val[6]));
    repeat (4) ser(32'h0);
    rd(vsc_reg_status);
    chk("miss set", 32'h1, 32'(rd_val[6]));
    wr(vsc_reg_ctrl, 32'h2);
    rd(vsc_reg_status);
    chk("miss clear", 32'h0, 32'(rd_val[6]));
    go(32'(vsc_op_mode_reset_refresh_cycle), 32'h0);
    wr(vsc_reg_ctrl, 32'h1);
    repeat (30) @(posedge clk);
    rd(vsc_reg_status);
    chk("auto refresh", 32'h1, 32'(rd_val[7] | rd_val[0]));
    wr(vsc_reg_ctrl, 32'h0);
    idle();
    chk("auto keeps", 32'h5, {vsc_dram_model_i.stop_mode, vsc_dram_model_i.code});
    finish_test();
  end
endmodule // vsc_host_bench
